// File: inc/atn_pkg.sv
// Functional notes
// RL1: opcode 27h queries native max, no parameters
// RL2: native max ignores any capacity cap
// RL3: 48-bit max split by upper_byte_select
// RL4: opcodes 20h and 21h both read sectors
// RL5: retry bit ignored, same behaviour
// RL6: fetch sectors from media, then send
// RL7: sector data moves as 16-bit words
// RL8: uncorrectable error stops at failing sector
// RL9: sector count zero means 256 sectors
// RL10: mode 0 start is cylinder/head/sector
// RL11: mode 1 start is 28-bit LBA
// RL12: count returns sectors not transferred
// RL13: address returns last transferred sector; after a media error the code returns the failing sector instead
// RL14: abort or media fault sets error flags
// RL15: device bit 6 selects CHS or LBA
package atn_pkg;
  localparam logic [7:0] CMD_NATIVE_MAX_EXT = 8'h27;
  localparam logic [7:0] CMD_READ_SECT      = 8'h20;
  localparam logic [7:0] CMD_READ_MASK      = 8'hfe;
  localparam int         DEV_MODE_BIT       = 6;
  localparam int         WORDS_PER_SECT     = 256;
  localparam logic [8:0] SECT_ZERO_COUNT    = 9'h100;
  localparam int         ST_BUSY = 7;
  localparam int         ST_RDY  = 6;
  localparam int         ST_DSC  = 4;
  localparam int         ST_DRQ  = 3;
  localparam int         ST_ERR  = 0;
  localparam int         ER_BAD_DATA = 6;
  localparam int         ER_NO_SECT  = 4;
  localparam int         ER_ABORTED  = 2;
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] STATUS_BUSY  = 8'h80;
  localparam logic [7:0] STATUS_DRQ   = 8'h58;
  localparam logic [7:0] STATUS_FAIL  = 8'h51;
  localparam logic [7:0] ERROR_RESET  = 8'h00;
  localparam logic [7:0] ERROR_ABORT  = 8'h04;
  localparam logic [47:0] NATIVE_MAX_DEF = 48'h0000_0fff_ffff;
  typedef enum logic [2:0] {
    ATN_IDLE  = 3'b000,
    ATN_FETCH = 3'b001,
    ATN_XFER  = 3'b011,
    ATN_DONE  = 3'b010,
    ATN_HOST_WAIT = 3'b110
  } atn_state_t;
endpackage

// File: inc/atn_if.sv
`timescale 1ns/1ps
`default_nettype none
// task-file link between host controller and drive
interface atn_if;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic [7:0]  count_in;
  logic [7:0]  lba_low_in;
  logic [7:0]  lba_mid_in;
  logic [7:0]  lba_high_in;
  logic [7:0]  device_in;
  logic        upper_byte_select;
  logic [7:0]  status;
  logic [7:0]  error;
  logic [7:0]  count_out;
  logic [7:0]  lba_low_out;
  logic [7:0]  lba_mid_out;
  logic [7:0]  lba_high_out;
  logic [7:0]  device_out;
  logic [15:0] data_word;
  logic        data_valid;
  logic        data_ready;
  modport dev (input cmd_valid, cmd_code, count_in, lba_low_in, lba_mid_in,
    lba_high_in, device_in, upper_byte_select, data_ready,
    output status, error, count_out, lba_low_out, lba_mid_out,
    lba_high_out, device_out, data_word, data_valid);
  modport hst (output cmd_valid, cmd_code, count_in, lba_low_in, lba_mid_in,
    lba_high_in, device_in, upper_byte_select, data_ready,
    input status, error, count_out, lba_low_out, lba_mid_out,
    lba_high_out, device_out, data_word, data_valid);
endinterface
`default_nettype wire

// File: logic/atn_device.sv
`timescale 1ns/1ps
`default_nettype none
module atn_device #(
  parameter logic [47:0] NATIVE_MAX = atn_pkg::NATIVE_MAX_DEF,
  parameter int          SECT_WORDS = atn_pkg::WORDS_PER_SECT
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  atn_if.dev               tf,
  output logic             media_req,
  output logic [27:0]      media_addr,
  output logic             media_chs,
  input  wire logic        media_ack,
  input  wire logic        media_unc,
  input  wire logic        media_idnf,
  input  wire logic [15:0] media_word
);
  import atn_pkg::*;

  atn_state_t  state;
  atn_state_t  next_state;
  logic [8:0]  remain;
  logic [8:0]  next_remain;
  logic [27:0] cur_addr;
  logic [27:0] next_addr;
  logic        lba_mode;
  logic        next_lba_mode;
  logic [8:0]  word_cnt;
  logic [8:0]  next_word_cnt;
  logic [47:0] max_hold;
  logic [47:0] next_max_hold;
  logic        is_max;
  logic        next_is_max;
  // registered copies of the task-file results
  logic [7:0]  status_q;
  logic [7:0]  next_status;
  logic [7:0]  error_q;
  logic [7:0]  next_error;
  logic [15:0] word_q;
  logic [15:0] next_word;

  // command decode; retry bit is masked off
  wire is_read = (tf.cmd_code & CMD_READ_MASK) == CMD_READ_SECT; // RL4 RL5
  wire is_maxq = tf.cmd_code == CMD_NATIVE_MAX_EXT; // RL1
  wire take    = tf.cmd_valid && state == ATN_IDLE;
  wire [8:0] req_cnt = (tf.count_in == 8'h00) ? SECT_ZERO_COUNT
                       : {1'b0, tf.count_in}; // RL9
  wire mode_l  = tf.device_in[DEV_MODE_BIT]; // RL15
  // CHS packs sector/cyl/head; LBA packs bits 27:0
  wire [27:0] start_addr = {tf.device_in[3:0], tf.lba_high_in,
                            tf.lba_mid_in, tf.lba_low_in}; // RL10 RL11
  wire word_last = word_cnt == 9'(SECT_WORDS - 1);
  wire beat      = tf.data_valid && tf.data_ready; // RL7
  wire media_bad = media_ack && (media_unc || media_idnf);
  // last sector of the command once its final word goes
  wire sect_last = remain == 9'h001;

  // next-state logic: fetch one sector, then stream it word by word
  always_comb
  begin
    next_state    = state;
    next_remain   = remain;
    next_addr     = cur_addr;
    next_lba_mode = lba_mode;
    next_word_cnt = word_cnt;
    next_max_hold = max_hold;
    next_is_max   = is_max;
    next_status   = status_q;
    next_error    = error_q;
    next_word     = word_q;
    case (state)
      ATN_IDLE:
        if (take)
        begin
          next_error = ERROR_RESET;
          if (is_maxq)
          begin
            // true limit: a capacity cap never narrows this answer
            next_max_hold = NATIVE_MAX; // RL2
            next_is_max   = 1'b1;
            next_status   = STATUS_RESET;
          end
          else if (is_read)
          begin
            next_remain   = req_cnt; // RL9
            next_addr     = start_addr;
            next_lba_mode = mode_l;
            next_is_max   = 1'b0;
            next_status   = STATUS_BUSY;
            next_state    = ATN_FETCH; // RL6
          end
          else
          begin
            // unknown opcode: refuse it and drop any old query result
            next_is_max = 1'b0;
            next_error  = ERROR_ABORT; // RL14
            next_status = STATUS_FAIL; // RL14
          end
        end
      ATN_FETCH:
        if (media_bad)
        begin
          // stop at the failing sector; address and count stay there
          next_error[ER_BAD_DATA] = media_unc; // RL8 RL14
          next_error[ER_NO_SECT]  = media_idnf && !media_unc; // RL14
          next_status             = STATUS_FAIL;
          next_state              = ATN_IDLE;
        end
        else if (media_ack)
        begin
          next_word     = media_word;
          next_word_cnt = 9'h000;
          next_status   = STATUS_DRQ;
          next_state    = ATN_XFER;
        end
      ATN_XFER:
        if (beat)
        begin
          next_word_cnt = word_cnt + 9'h001;
          if (!word_last)
            next_word = media_word;
          else
          begin
            next_remain = remain - 9'h001; // RL12
            if (sect_last)
            begin
              // address stays on the last sector sent
              next_status = STATUS_RESET;
              next_state  = ATN_DONE;
            end
            else
            begin
              next_addr   = cur_addr + 28'h1;
              next_status = STATUS_BUSY;
              next_state  = ATN_FETCH;
            end
          end
        end
      // one extra step keeps the exit to idle a one-bit change
      ATN_DONE:
        next_state = ATN_IDLE;
      default:
        next_state = ATN_IDLE;
    endcase
  end

  // sequence registers
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      state    <= ATN_IDLE;
      remain   <= 9'h000;
      cur_addr <= 28'h0;
      lba_mode <= 1'b0;
      word_cnt <= 9'h000;
    end
    else
    begin
      state    <= next_state;
      remain   <= next_remain;
      cur_addr <= next_addr;
      lba_mode <= next_lba_mode;
      word_cnt <= next_word_cnt;
    end
  end

  // registers the host reads back; reset shows ready and seek done
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      status_q <= STATUS_RESET;
      error_q  <= ERROR_RESET;
      max_hold <= 48'h0;
      is_max   <= 1'b0;
      word_q   <= 16'h0000;
    end
    else
    begin
      status_q <= next_status;
      error_q  <= next_error;
      max_hold <= next_max_hold;
      is_max   <= next_is_max;
      word_q   <= next_word;
    end
  end

  // media port: one sector per request, address in caller's mode
  assign media_req  = state == ATN_FETCH;
  assign media_addr = cur_addr;
  assign media_chs  = !lba_mode;
  assign tf.data_valid = state == ATN_XFER;

  // status, error and data word come straight from flip-flops
  assign tf.status    = status_q;
  assign tf.error     = error_q;
  assign tf.data_word = word_q;

  // result registers: count left and last sector, or native max
  wire [7:0] max_lo = tf.upper_byte_select ? max_hold[31:24] : max_hold[7:0];
  wire [7:0] max_md = tf.upper_byte_select ? max_hold[39:32] : max_hold[15:8];
  wire [7:0] max_hi = tf.upper_byte_select ? max_hold[47:40] : max_hold[23:16];
  assign tf.count_out    = is_max ? 8'h00 : remain[7:0]; // RL12
  assign tf.lba_low_out  = is_max ? max_lo : cur_addr[7:0]; // RL3 RL13
  assign tf.lba_mid_out  = is_max ? max_md : cur_addr[15:8]; // RL3 RL13
  assign tf.lba_high_out = is_max ? max_hi : cur_addr[23:16]; // RL3 RL13
  assign tf.device_out   = is_max ? 8'h00 : {4'h0, cur_addr[27:24]}; // RL13
endmodule // atn_device
`default_nettype wire

// File: logic/atn_host.sv
`timescale 1ns/1ps
`default_nettype none
module atn_host (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  atn_if.hst               tf,
  input  wire logic        go,
  input  wire logic [7:0]  go_cmd,
  input  wire logic [7:0]  go_count,
  input  wire logic [27:0] go_addr,
  input  wire logic        go_lba,
  input  wire logic        go_upper,
  input  wire logic        word_ready,
  output logic [15:0]      word_data,
  output logic             word_valid,
  output logic             busy
);
  import atn_pkg::*;

  logic        pend;
  logic [7:0]  cmd;
  logic [7:0]  cnt;
  logic [27:0] addr;
  logic        lba;
  logic        upper;

  // capture user command; issue for one cycle
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pend <= 1'b0;
      cmd <= 8'h00;
      cnt <= 8'h00;
      addr <= 28'h0;
      lba <= 1'b0;
      upper <= 1'b0;
      busy <= 1'b0;
      word_data <= 16'h0000;
      word_valid <= 1'b0;
    end
    else
    begin
      pend <= go && !busy;
      if (go && !busy)
      begin
        cmd <= go_cmd; // RL1 RL4
        cnt <= go_count;
        addr <= go_addr;
        lba <= go_lba;
        upper <= go_upper;
        busy <= 1'b1;
      end
      else if (!pend && !tf.status[ST_BUSY] && !tf.status[ST_DRQ])
        busy <= 1'b0;
      // sample data word per beat
      word_valid <= tf.data_valid && word_ready; // RL7
      if (tf.data_valid && word_ready)
        word_data <= tf.data_word;
    end
  end

  // task file drive; address packing per mode
  assign tf.cmd_valid   = pend;
  assign tf.cmd_code    = cmd;
  assign tf.count_in    = cnt;
  assign tf.lba_low_in  = addr[7:0]; // RL10 RL11
  assign tf.lba_mid_in  = addr[15:8];
  assign tf.lba_high_in = addr[23:16];
  assign tf.device_in   = {1'b0, lba, 2'b00, addr[27:24]}; // RL15
  assign tf.upper_byte_select = upper; // RL3
  assign tf.data_ready  = word_ready;
endmodule // atn_host
`default_nettype wire

// File: dv/atn_checker.sv
`timescale 1ns/1ps
`default_nettype none
module atn_checker
  import atn_pkg::*;
#(parameter logic [47:0] NATIVE_MAX = 48'h0)
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic       upper_byte_select,
  input wire logic [7:0] status,
  input wire logic [7:0] error,
  input wire logic [7:0] count_out,
  input wire logic [7:0] lba_low_out,
  input wire logic [7:0] lba_mid_out,
  input wire logic [7:0] lba_high_out,
  input wire logic       data_valid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // commands are only taken with busy and drq both low
  wire        take = cmd_valid && !status[ST_BUSY] && !status[ST_DRQ];
  wire        is_rd = cmd_code[7:1] == 7'h10;
  wire [23:0] lba = {lba_high_out, lba_mid_out, lba_low_out};
  property p_max;
    take && cmd_code == 8'h27 |=> status == 8'h50 && lba ==
      (upper_byte_select ? NATIVE_MAX[47:24] : NATIVE_MAX[23:0]);
  endproperty
  a_max: assert property (p_max) else $error("bad native max");
  property p_qry;
    take && cmd_code == 8'h27 |=> error == 8'h00;
  endproperty
  a_qry: assert property (p_qry) else $error("query refused");
  property p_rd;
    take && is_rd |=> status == 8'h80;
  endproperty
  a_rd: assert property (p_rd) else $error("read not started");
  property p_bad;
    take && !is_rd && cmd_code != 8'h27 |=> status == 8'h51 ##0
      error == 8'h04;
  endproperty
  a_bad: assert property (p_bad) else $error("no abort");
  property p_drq;
    data_valid |-> status[ST_DRQ];
  endproperty
  a_drq: assert property (p_drq) else $error("word without drq");
  property p_stop;
    status[ST_ERR] |-> !data_valid;
  endproperty
  a_stop: assert property (p_stop) else $error("data after error");
  property p_cnt;
    $past(status) == 8'h58 && status == 8'h50 |-> count_out == 8'h00;
  endproperty
  a_cnt: assert property (p_cnt) else $error("count left");
  property p_flag;
    $rose(status[ST_ERR]) |-> error[ER_ABORTED] || error[ER_BAD_DATA] ||
      error[ER_NO_SECT];
  endproperty
  a_flag: assert property (p_flag) else $error("no cause");
endmodule // atn_checker
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import atn_pkg::*;
  localparam int          SW = 4;
  localparam logic [47:0] NM = 48'ha1b2_c3d4_e5f6;
  logic        mclk, rst_n, go, go_lba, go_upper, busy, word_valid, fu;
  logic        media_req, media_chs, media_unc, media_idnf;
  logic        media_ack = 1'b0;
  logic        word_ready = 1'b1;
  logic [7:0]  go_cmd, go_count;
  logic [8:0]  fail_at;
  logic        stall = 1'b0;
  logic [7:0]  widx = 8'h00;
  logic [8:0]  n_acks = 9'h000;
  logic [27:0] go_addr, media_addr;
  logic [15:0] word_data, media_word;
  logic [15:0] q[$];
  int          n_errors, total_checks;
  atn_if tf();
  atn_device #(.NATIVE_MAX(NM), .SECT_WORDS(SW)) i_atn_device (.mclk,
    .rst_n, .tf(tf.dev), .media_req, .media_addr, .media_chs, .media_ack,
    .media_unc, .media_idnf, .media_word);
  atn_host i_atn_host (.mclk, .rst_n, .tf(tf.hst), .go, .go_cmd,
    .go_count, .go_addr, .go_lba, .go_upper, .word_ready, .word_data,
    .word_valid, .busy);
  atn_checker #(.NATIVE_MAX(NM)) i_atn_checker (.mclk, .rst_n,
    .cmd_valid(tf.cmd_valid), .cmd_code(tf.cmd_code),
    .upper_byte_select(tf.upper_byte_select), .status(tf.status),
    .error(tf.error), .count_out(tf.count_out),
    .lba_low_out(tf.lba_low_out), .lba_mid_out(tf.lba_mid_out),
    .lba_high_out(tf.lba_high_out), .data_valid(tf.data_valid));
  // media answers a cycle after each request; words carry the low
  // address byte and index so misordered sectors or words show up
  assign media_word = {media_addr[7:0], widx};
  assign media_unc  = media_ack && n_acks == fail_at && fu;
  assign media_idnf = media_ack && n_acks == fail_at && !fu;
  always @(posedge mclk)
  begin
    media_ack <= media_req && !media_ack;
    // index counts the word taken at ack and each beat after it
    widx <= (media_req && !media_ack) ? 8'h00
            : widx + 8'(media_ack || (tf.data_valid && tf.data_ready));
    n_acks <= go ? 9'h000 : n_acks + 9'(media_ack);
    // a stalled host takes a word only every other cycle
    word_ready <= !(stall && word_ready);
  end
  // sample host words mid-cycle, well clear of the launching edge
  always @(negedge mclk)
    if (word_valid === 1'b1) q.push_back(word_data);
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task test_done;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task issue(input logic [7:0] c, n, input logic [27:0] a, input logic l, u);
    int i;
    @(posedge mclk);
    #1 go = 1'b1;
    {go_cmd, go_count, go_addr, go_lba, go_upper} = {c, n, a, l, u};
    q.delete();
    @(posedge mclk);
    #1 go = 1'b0;
    i = 0;
    repeat (2) @(posedge mclk);
    #1;
    while (busy !== 1'b0)
    begin
      if (++i > 20000)
      begin
        n_errors++;
        test_done;
      end
      @(posedge mclk);
      #1;
    end
  endtask
  task t_max(input logic u);
    issue(8'h27, 8'h00, 28'h0, 1'b1, u);
    chk({tf.lba_high_out, tf.lba_mid_out, tf.lba_low_out},
      u ? NM[47:24] : NM[23:0]);
  endtask
  task t_read(input logic [7:0] c, n8, input logic [27:0] a,
    input logic l, input int fa, input logic f);
    int n, m;
    fail_at = 9'(fa);
    fu = f;
    n = (n8 == 8'h00) ? 256 : n8;
    m = (fa < n) ? fa : n;
    issue(c, n8, a, l, 1'b0);
    chk(q.size(), m * SW);
    if (q.size() == m * SW)
      for (int s = 0; s < m * SW; s++)
        chk(q[s], {a[7:0] + 8'(s / SW), 8'(s % SW)});
    chk({tf.device_out[3:0], tf.lba_high_out, tf.lba_mid_out,
      tf.lba_low_out}, (m < n) ? a + m : a + m - 1);
    chk(tf.count_out, 8'(n - m));
    chk({tf.status, tf.error}, (m < n) ? {8'h51, f ? 8'h40 : 8'h10}
      : 16'h5000);
    chk(media_chs, !l);
  endtask
  initial
  begin
    {rst_n, go, go_cmd, go_count, go_addr, go_lba, go_upper} = '0;
    {fail_at, fu} = {9'h1ff, 1'b0};
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_max(1'b0);
    t_max(1'b1);
    t_read(8'h20, 8'h02, 28'h0abcdef, 1'b1, 255, 1'b0);
    stall = 1'b1;
    t_read(8'h21, 8'h01, 28'h3010507, 1'b0, 255, 1'b0);
    stall = 1'b0;
    t_read(8'h20, 8'h00, 28'h0000010, 1'b1, 511, 1'b0);
    t_read(8'h21, 8'h03, 28'h00000fe, 1'b1, 1, 1'b1);
    t_read(8'h20, 8'h02, 28'h0000020, 1'b1, 0, 1'b0);
    issue(8'hec, 8'h01, 28'h0, 1'b1, 1'b0);
    chk({tf.status, tf.error}, 16'h5104);
    test_done;
  end
endmodule // testbench
`default_nettype wire
